// ===== imp_controller.sv
// Interrupt controller: masks, global enable, priority bytes and pending flags for 23 sources.
// Assumes level and edge request inputs come from logic on clock_i, so they are not synchronised.
// Operation
// - First mask byte gates eight level sources.
// - Second mask byte gates eight more level sources.
// - Third mask byte gates edge sources, bit7 reserved.
// - No request unless global enable bit set.
// - Software sets mask first, then global enable.
// - Priority bytes: one marks source high priority.
// - High priority sources served before low ones.
// - Software sets priority bits by command; bytes reset low.
// - Raised request sets its pending flag.
// - Pending bytes form 24-bit word matching masks.
// - Edge flag held until write-one clears it.
// - Level flag follows module status only.
// - Sixteen level plus seven edge sources.
`timescale 1ns/1ps
module imp_controller
	import imp_pkg::*;
	(
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	imp_link_if.dev                   link,
	input  wire logic [NUM_LEVEL-1:0] level_req_i,
	input  wire logic [NUM_EDGE-1:0]  edge_req_i
	);

	logic [7:0]           mask_low;
	logic [7:0]           mask_high;
	logic [NUM_EDGE-1:0]  mask_edge;
	logic                 global_enable;
	logic [NUM_SRC-1:0]   priority_word;
	logic [NUM_LEVEL-1:0] level_flag;
	logic [NUM_EDGE-1:0]  edge_flag;
	logic [NUM_EDGE-1:0]  edge_prev;
	logic [NUM_EDGE-1:0]  edge_rise;
	logic [NUM_EDGE-1:0]  edge_clear;
	logic [NUM_SRC-1:0]   flag_word;
	logic [NUM_SRC-1:0]   mask_word;
	logic [NUM_SRC-1:0]   pending;
	logic [7:0]           next_rdata;
	logic                 wr_hit;

	// Pick the source to serve: high priority first, then lowest index
	// A fixed scan keeps the choice repeatable; a busy low index can starve higher ones
	function automatic logic [ID_W-1:0] pick_source(input logic [NUM_SRC-1:0] pend,
	                                               input logic [NUM_SRC-1:0] prio);
		logic [ID_W-1:0] id;
		logic            found;
		id    = RST_ID;
		found = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (!found && pend[i] && prio[i]) begin
				id    = ID_W'(i);
				found = 1'b1;
			end
		end
		for (int i = 0; i < NUM_SRC; i++) begin
			if (!found && pend[i]) begin
				id    = ID_W'(i);
				found = 1'b1;
			end
		end
		return id;
	endfunction

	assign wr_hit = link.reg_wr;

	// Mask bytes; reserved edge bit is not stored and reads zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mask_low  <= RST_BYTE;
			mask_high <= RST_BYTE;
			mask_edge <= RST_BYTE[NUM_EDGE-1:0];
		end else if (wr_hit) begin
			if (link.reg_addr == OFF_LEVEL_MASK_LOW) begin
				mask_low <= link.reg_wdata;
			end
			if (link.reg_addr == OFF_LEVEL_MASK_HIGH) begin
				mask_high <= link.reg_wdata;
			end
			if (link.reg_addr == OFF_EDGE_MASK) begin
				mask_edge <= link.reg_wdata[NUM_EDGE-1:0];
			end
		end
	end

	// Global enable; bits 7:1 are reserved and not kept
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			global_enable <= 1'b0;
		end else if (wr_hit && link.reg_addr == OFF_GLOBAL_ENABLE) begin
			global_enable <= link.reg_wdata[GLOBAL_ENABLE_BIT];
		end
	end

	// Priority bytes, one bit per source at the mask bit position
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			priority_word <= RST_WORD;
		end else if (wr_hit) begin
			if (link.reg_addr == OFF_PRIORITY0) begin
				priority_word[7:0] <= link.reg_wdata;
			end
			if (link.reg_addr == OFF_PRIORITY1) begin
				priority_word[15:8] <= link.reg_wdata;
			end
			if (link.reg_addr == OFF_PRIORITY2) begin
				priority_word[23:16] <= {1'b0, link.reg_wdata[NUM_EDGE-1:0]};
			end
		end
	end

	// Level flags mirror the module status; only the module can clear them
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			level_flag <= RST_WORD[NUM_LEVEL-1:0];
		end else begin
			level_flag <= level_req_i;
		end
	end

	// Rising edge detect and write-one-to-clear for edge flags
	assign edge_rise  = edge_req_i & ~edge_prev;
	assign edge_clear = (wr_hit && link.reg_addr == OFF_PENDING2) ?
	                    link.reg_wdata[NUM_EDGE-1:0] : RST_BYTE[NUM_EDGE-1:0];

	// Previous source level; resets to the idle level so no false rise follows reset
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			edge_prev <= RST_BYTE[NUM_EDGE-1:0];
		end else begin
			edge_prev <= edge_req_i;
		end
	end

	// A rise in the clearing cycle survives, so no event is lost
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			edge_flag <= RST_BYTE[NUM_EDGE-1:0];
		end else begin
			edge_flag <= (edge_flag & ~edge_clear) | edge_rise;
		end
	end

	// 24-bit views: level bytes low, edge byte high with bit 23 zero
	assign flag_word = {1'b0, edge_flag, level_flag};
	assign mask_word = {1'b0, mask_edge, mask_high, mask_low};
	assign pending   = flag_word & mask_word;

	// Request to the core, registered so it comes straight from a flop
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link.irq_req <= 1'b0;
		end else begin
			link.irq_req <= global_enable && (|pending);
		end
	end

	// Marks that a high priority source waits, so the core can serve it first
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link.irq_high <= 1'b0;
		end else begin
			link.irq_high <= global_enable && (|(pending & priority_word));
		end
	end

	// Source to serve first; costs one cycle of latency but no long path to the core
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link.irq_src_id <= RST_ID;
		end else begin
			link.irq_src_id <= pick_source(pending, priority_word);
		end
	end

	// Read decode; unmapped addresses and reserved bits read zero
	always_comb begin
		next_rdata = RST_BYTE;
		case (link.reg_addr)
			OFF_LEVEL_MASK_LOW:  next_rdata = mask_low;
			OFF_LEVEL_MASK_HIGH: next_rdata = mask_high;
			OFF_EDGE_MASK:       next_rdata = {1'b0, mask_edge};
			OFF_GLOBAL_ENABLE:   next_rdata = {7'h00, global_enable};
			OFF_PRIORITY0:       next_rdata = priority_word[7:0];
			OFF_PRIORITY1:       next_rdata = priority_word[15:8];
			OFF_PRIORITY2:       next_rdata = priority_word[23:16];
			OFF_PENDING0:        next_rdata = flag_word[7:0];
			OFF_PENDING1:        next_rdata = flag_word[15:8];
			OFF_PENDING2:        next_rdata = flag_word[23:16];
			default:             next_rdata = RST_BYTE;
		endcase
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link.reg_rvalid <= 1'b0;
		end else begin
			link.reg_rvalid <= link.reg_rd;
		end
	end

	// Read data holds until the next read, so a slow reader still sees it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link.reg_rdata <= RST_BYTE;
		end else if (link.reg_rd) begin
			link.reg_rdata <= next_rdata;
		end
	end

endmodule

// ===== imp_pkg.sv
// Constants and types shared by the interrupt controller and its processor-side end.
// Assumes one system clock and a synchronous active-high reset in every user.
package imp_pkg;

	// Source counts
	localparam int NUM_SRC       = 24;
	localparam int NUM_LEVEL     = 16;
	localparam int NUM_EDGE      = 7;        // Edge byte bit 7 is reserved and has no source
	localparam int ADDR_W        = 12;
	localparam int ID_W          = 5;

	// Register offsets, one byte each
	localparam logic [11:0] OFF_LEVEL_MASK_LOW  = 12'h640;
	localparam logic [11:0] OFF_LEVEL_MASK_HIGH = 12'h641;
	localparam logic [11:0] OFF_EDGE_MASK       = 12'h642;
	localparam logic [11:0] OFF_GLOBAL_ENABLE   = 12'h643;
	localparam logic [11:0] OFF_PRIORITY0       = 12'h644;
	localparam logic [11:0] OFF_PRIORITY1       = 12'h645;
	localparam logic [11:0] OFF_PRIORITY2       = 12'h646;
	localparam logic [11:0] OFF_PENDING0        = 12'h648;
	localparam logic [11:0] OFF_PENDING1        = 12'h649;
	localparam logic [11:0] OFF_PENDING2        = 12'h64a;

	// Field positions
	localparam int GLOBAL_ENABLE_BIT = 0;
	localparam int EDGE_BASE         = 16;    // Flag bit of the bus idle event

	// Values after reset
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [23:0] RST_WORD   = 24'h000000;
	localparam logic [4:0]  RST_ID     = 5'h00;
	localparam logic [11:0] RST_ADDR   = 12'h000;

	// Hold counter start after servicing; the processor end waits this many cycles plus one before it looks at the request again
	localparam logic [1:0]  HOLDOFF_CYCLES = 2'h3;

	// Processor end commands
	typedef enum logic [1:0] {
		IMP_CMD_ENABLE,
		IMP_CMD_DISABLE,
		IMP_CMD_PRIO_HIGH
	} imp_cmd_t;

endpackage

// ===== imp_link_if.sv
// Interface joining the interrupt controller and the processor core end.
// Assumes both ends share clock_i; level resolution of nets is not needed (no two-way pins).
`timescale 1ns/1ps
interface imp_link_if
	import imp_pkg::*;
	();
	logic [ADDR_W-1:0] reg_addr;     // Byte address of register access
	logic              reg_wr;       // One-cycle write strobe
	logic              reg_rd;       // One-cycle read strobe
	logic [7:0]        reg_wdata;    // Write data
	logic [7:0]        reg_rdata;    // Read data, valid with reg_rvalid
	logic              reg_rvalid;   // One cycle after reg_rd
	logic              irq_req;      // Request to the processor
	logic              irq_high;     // Some pending enabled source is high priority
	logic [ID_W-1:0]   irq_src_id;   // Source to serve first

	modport dev (
		input  reg_addr, reg_wr, reg_rd, reg_wdata,
		output reg_rdata, reg_rvalid, irq_req, irq_high, irq_src_id
	);

	modport cpu (
		output reg_addr, reg_wr, reg_rd, reg_wdata,
		input  reg_rdata, reg_rvalid, irq_req, irq_high, irq_src_id
	);
endinterface

// ===== imp_core_end.sv
// Processor-side end: enables or disables sources and services requests over the register port.
// Assumes it is the only writer of the controller registers, so it keeps a shadow of the masks.
`timescale 1ns/1ps
module imp_core_end
	import imp_pkg::*;
	(
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	imp_link_if.cpu                   link,
	input  wire logic                 cmd_valid_i,
	input  wire imp_cmd_t             cmd_op_i,
	input  wire logic [ID_W-1:0]      cmd_src_i,
	output logic                      busy_o,
	output logic                      cmd_done_o,
	output logic                      serviced_valid_o,
	output logic [ID_W-1:0]           serviced_src_o,
	output logic [NUM_LEVEL-1:0]      level_clear_o
	);

	typedef enum logic [2:0] {
		IMP_IDLE,
		IMP_WR_MASK,
		IMP_WR_ENABLE,
		IMP_RD_FLAG,
		IMP_WAIT_FLAG,
		IMP_CLEAR,
		IMP_HOLD
	} imp_state_t;

	imp_state_t         state;
	logic [NUM_SRC-1:0] shadow_mask;
	logic [NUM_SRC-1:0] shadow_prio;
	logic               prio_cmd;
	logic [NUM_SRC-1:0] flags;
	logic [1:0]         byte_idx;
	logic [1:0]         hold_cnt;
	logic [ID_W-1:0]    cur_src;

	// Byte address of a 24-bit word byte starting at a base offset
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] base, input logic [1:0] idx);
		return base + {10'h000, idx};
	endfunction

	// Sequencer: commands first, otherwise service a pending request
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state            <= IMP_IDLE;
			shadow_mask      <= RST_WORD;
			shadow_prio      <= RST_WORD;
			prio_cmd         <= 1'b0;
			flags            <= RST_WORD;
			byte_idx         <= 2'h0;
			hold_cnt         <= 2'h0;
			cur_src          <= RST_ID;
			link.reg_addr    <= RST_ADDR;
			link.reg_wr      <= 1'b0;
			link.reg_rd      <= 1'b0;
			link.reg_wdata   <= RST_BYTE;
			busy_o           <= 1'b0;
			cmd_done_o       <= 1'b0;
			serviced_valid_o <= 1'b0;
			serviced_src_o   <= RST_ID;
			level_clear_o    <= RST_WORD[NUM_LEVEL-1:0];
		end else begin
			link.reg_wr      <= 1'b0;
			link.reg_rd      <= 1'b0;
			cmd_done_o       <= 1'b0;
			serviced_valid_o <= 1'b0;
			level_clear_o    <= RST_WORD[NUM_LEVEL-1:0];
			case (state)
				IMP_IDLE: begin
					// Bit 23 is reserved, so a command naming it is dropped
					if (cmd_valid_i && cmd_src_i != ID_W'(NUM_SRC - 1)) begin
						cur_src  <= cmd_src_i;
						prio_cmd <= (cmd_op_i == IMP_CMD_PRIO_HIGH);
						case (cmd_op_i)
							IMP_CMD_ENABLE: begin
								shadow_mask[cmd_src_i] <= 1'b1;
							end
							IMP_CMD_PRIO_HIGH: begin
								shadow_prio[cmd_src_i] <= 1'b1;
							end
							default: begin
								shadow_mask[cmd_src_i] <= 1'b0;
							end
						endcase
						busy_o <= 1'b1;
						state  <= IMP_WR_MASK;
					end else if (link.irq_req) begin
						byte_idx <= 2'h0;
						busy_o   <= 1'b1;
						state    <= IMP_RD_FLAG;
					end else begin
						busy_o <= 1'b0;
					end
				end
				IMP_WR_MASK: begin
					if (prio_cmd) begin
						// Priority change needs no enable write after it
						link.reg_addr  <= byte_addr(OFF_PRIORITY0, cur_src[4:3]);
						link.reg_wdata <= shadow_prio[{cur_src[4:3], 3'h0} +: 8];
						link.reg_wr    <= 1'b1;
						cmd_done_o     <= 1'b1;
						state          <= IMP_IDLE;
					end else begin
						// Mask is written before the global enable
						link.reg_addr  <= byte_addr(OFF_LEVEL_MASK_LOW, cur_src[4:3]);
						link.reg_wdata <= shadow_mask[{cur_src[4:3], 3'h0} +: 8];
						link.reg_wr    <= 1'b1;
						state          <= IMP_WR_ENABLE;
					end
				end
				IMP_WR_ENABLE: begin
					link.reg_addr  <= OFF_GLOBAL_ENABLE;
					link.reg_wdata <= 8'h01;
					link.reg_wr    <= 1'b1;
					cmd_done_o     <= 1'b1;
					state          <= IMP_IDLE;
				end
				IMP_RD_FLAG: begin
					link.reg_addr <= byte_addr(OFF_PENDING0, byte_idx);
					link.reg_rd   <= 1'b1;
					state         <= IMP_WAIT_FLAG;
				end
				IMP_WAIT_FLAG: begin
					if (link.reg_rvalid) begin
						flags[{byte_idx, 3'h0} +: 8] <= link.reg_rdata;
						if (byte_idx == 2'h2) begin
							cur_src <= link.irq_src_id;
							state   <= IMP_CLEAR;
						end else begin
							byte_idx <= byte_idx + 2'h1;
							state    <= IMP_RD_FLAG;
						end
					end
				end
				IMP_CLEAR: begin
					// Edge flags clear by register write, level ones at the module
					if (flags[cur_src] && cur_src >= ID_W'(EDGE_BASE)) begin
						link.reg_addr  <= OFF_PENDING2;
						link.reg_wdata <= 8'h01 << cur_src[2:0];
						link.reg_wr    <= 1'b1;
					end else if (flags[cur_src]) begin
						level_clear_o[cur_src[3:0]] <= 1'b1;
					end
					serviced_valid_o <= flags[cur_src];
					serviced_src_o   <= cur_src;
					hold_cnt         <= HOLDOFF_CYCLES;
					state            <= IMP_HOLD;
				end
				IMP_HOLD: begin
					// Lets the cleared flag reach the registered request before looking again
					if (hold_cnt == 2'h0) begin
						state <= IMP_IDLE;
					end else begin
						hold_cnt <= hold_cnt - 2'h1;
					end
				end
				default: begin
					state <= IMP_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== imp_link_checker.sv
// Assertions on the link between the controller and the processor end.
// Assumes one clock and that the processor end is the only register writer.
`timescale 1ns/1ps
module imp_link_checker
	import imp_pkg::*;
	(
	input wire logic              clock_i,
	input wire logic              reset_i,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_wdata,
	input wire logic [7:0]        reg_rdata,
	input wire logic              reg_rvalid,
	input wire logic              irq_req,
	input wire logic              irq_high,
	input wire logic [ID_W-1:0]   irq_src_id
	);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic [23:0] mask_q;
	logic [23:0] mask_d;
	logic        en_q;
	logic        prio_wr;
	logic [23:0] prio_q;
	logic [23:0] prio_d;
	// Shadow of the priority bytes, taken from the writes on the link
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			prio_q <= RST_WORD;
		end else if (reg_wr && reg_addr >= OFF_PRIORITY0 && reg_addr <= OFF_PRIORITY2) begin
			prio_q[{reg_addr[1:0], 3'h0} +: 8] <= reg_wdata;
		end
	end
	// Delayed copy, matching the one cycle the request logic takes
	always_ff @(posedge clock_i) begin
		prio_d <= reset_i ? RST_WORD : prio_q;
	end
	// Shadow of the mask bytes, taken from the writes on the link
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mask_q <= RST_WORD;
		end else if (reg_wr && reg_addr >= OFF_LEVEL_MASK_LOW && reg_addr <= OFF_EDGE_MASK) begin
			mask_q[{reg_addr[1:0], 3'h0} +: 8] <= reg_wdata;
		end
	end
	// Delayed copy, since the request lags a mask change by one cycle
	always_ff @(posedge clock_i) begin
		mask_d <= reset_i ? RST_WORD : mask_q;
	end
	// Shadow of the global enable bit
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			en_q <= 1'b0;
		end else if (reg_wr && reg_addr == OFF_GLOBAL_ENABLE) begin
			en_q <= reg_wdata[GLOBAL_ENABLE_BIT];
		end
	end
	// Remembers any write to the priority bytes
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			prio_wr <= 1'b0;
		end else if (reg_wr && reg_addr >= OFF_PRIORITY0 && reg_addr <= OFF_PRIORITY2) begin
			prio_wr <= 1'b1;
		end
	end
	a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read got no answer");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
	a_rdata_hold: assert property (!reg_rvalid && !$past(reset_i) |-> $stable(reg_rdata))
		else $error("read data moved without answer");
	a_edge_rsvd: assert property (reg_rd && reg_addr == OFF_PENDING2 |=> !reg_rdata[7])
		else $error("reserved edge flag set");
	a_req_enable: assert property (irq_req |-> $past(en_q)) else $error("request while disabled");
	a_req_masked: assert property (irq_req |-> mask_d[irq_src_id]) else $error("request from masked source");
	a_src_valid: assert property (irq_req |-> irq_src_id < 5'h17) else $error("request names no source");
	a_prio_low: assert property (!prio_wr |-> !irq_high) else $error("high priority with bytes at reset");
	a_mask_first: assert property (reg_wr && reg_addr == OFF_GLOBAL_ENABLE |-> $past(reg_wr) && $past(reg_addr) <= OFF_EDGE_MASK)
		else $error("enable written without mask write before it");
	a_clear_onehot: assert property (reg_wr && reg_addr == OFF_PENDING2 |-> $onehot(reg_wdata[6:0]) && !reg_wdata[7])
		else $error("bad edge flag clear");
	a_high_first: assert property (irq_high |-> irq_req && prio_d[irq_src_id])
		else $error("high priority source not served first");
	c_req: cover property ($rose(irq_req));
	c_high: cover property (irq_high);
	c_edge_clear: cover property (reg_wr && reg_addr == OFF_PENDING2);
	c_enable: cover property (reg_wr && reg_addr == OFF_GLOBAL_ENABLE);
endmodule

// ===== irq_mask_priority_controller_tb_top.sv
// Bench joining controller and processor end; stands in for the source modules.
// Assumes the package constants; commands are only issued with no request pending.
`timescale 1ns/1ps
module irq_mask_priority_controller_tb_top
	import imp_pkg::*;
	();
	logic                 clock_i;
	logic                 reset_i;
	logic                 cmd_valid_i;
	imp_cmd_t             cmd_op_i;
	logic [ID_W-1:0]      cmd_src_i;
	logic [NUM_LEVEL-1:0] level_req_i;
	logic [NUM_EDGE-1:0]  edge_req_i;
	logic                 busy_o;
	logic                 cmd_done_o;
	logic                 serviced_valid_o;
	logic [ID_W-1:0]      serviced_src_o;
	logic [NUM_LEVEL-1:0] level_clear_o;
	logic [23:0]          src_set;
	logic [ID_W-1:0]      served_q[$];
	int                   miscompares;
	int                   comparisons;
	imp_link_if u_imp_link_if ();
	imp_controller u_imp_controller (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.link        (u_imp_link_if),
		.level_req_i (level_req_i),
		.edge_req_i  (edge_req_i)
	);
	imp_core_end u_imp_core_end (
		.clock_i          (clock_i),
		.reset_i          (reset_i),
		.link             (u_imp_link_if),
		.cmd_valid_i      (cmd_valid_i),
		.cmd_op_i         (cmd_op_i),
		.cmd_src_i        (cmd_src_i),
		.busy_o           (busy_o),
		.cmd_done_o       (cmd_done_o),
		.serviced_valid_o (serviced_valid_o),
		.serviced_src_o   (serviced_src_o),
		.level_clear_o    (level_clear_o)
	);
	imp_link_checker u_imp_link_checker (
		.clock_i    (clock_i),
		.reset_i    (reset_i),
		.reg_addr   (u_imp_link_if.reg_addr),
		.reg_wr     (u_imp_link_if.reg_wr),
		.reg_rd     (u_imp_link_if.reg_rd),
		.reg_wdata  (u_imp_link_if.reg_wdata),
		.reg_rdata  (u_imp_link_if.reg_rdata),
		.reg_rvalid (u_imp_link_if.reg_rvalid),
		.irq_req    (u_imp_link_if.irq_req),
		.irq_high   (u_imp_link_if.irq_high),
		.irq_src_id (u_imp_link_if.irq_src_id)
	);
	// Source modules: level status holds until cleared, edges follow src_set; services are logged
	always @(posedge clock_i) begin
		level_req_i <= reset_i ? 16'h0000 : (level_req_i | src_set[15:0]) & ~level_clear_o;
		edge_req_i  <= src_set[22:16];
		if (serviced_valid_o === 1'b1) begin
			served_q.push_back(serviced_src_o);
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// A service in progress would swallow the command, hence the caller's restriction
	task automatic do_cmd(input imp_cmd_t op, input logic [4:0] src);
		int k;
		k = 0;
		@(posedge clock_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i    <= op;
		cmd_src_i   <= src;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		while (cmd_done_o !== 1'b1 && k < 10) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		check(24'(cmd_done_o), 24'h000001);
		check(24'(busy_o), 24'h000001);
	endtask
	task automatic fire(input logic [23:0] v);
		@(posedge clock_i);
		src_set <= v;
		@(posedge clock_i);
		src_set <= 24'h000000;
	endtask
	// Quiet span after the last service catches a flag that failed to clear
	task automatic expect_srv(input int n, input logic [4:0] a, input logic [4:0] b);
		int k;
		k = 0;
		while (served_q.size() < n && k < 100) begin
			@(posedge clock_i);
			k++;
		end
		repeat (30) @(posedge clock_i);
		check(24'(served_q.size()), 24'(n));
		check(24'(busy_o), 24'h000000);
		if (n > 0) check(24'(served_q[0]), 24'(a));
		if (n > 1) check(24'(served_q[1]), 24'(b));
		served_q.delete();
	endtask
	function automatic logic [4:0] lower(input logic [4:0] a, input logic [4:0] b);
		return (a < b) ? a : b;
	endfunction
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		end_sim();
	end
	initial begin
		logic [4:0] a;
		logic [4:0] b;
		reset_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_op_i = IMP_CMD_ENABLE;
		cmd_src_i = 5'h00;
		src_set = 24'h000000;
		miscompares = 0;
		comparisons = 0;
		void'($urandom(6));
		repeat (4) @(posedge clock_i);
		reset_i <= 1'b0;
		fire(24'h000008);
		expect_srv(0, 5'h00, 5'h00);
		check(24'(u_imp_link_if.irq_req), 24'h000000);
		do_cmd(IMP_CMD_ENABLE, 5'h03);
		expect_srv(1, 5'h03, 5'h00);
		for (int s = 0; s < 23; s++) begin
			do_cmd(IMP_CMD_ENABLE, 5'(s));
			fire(24'h000001 << s);
			expect_srv(1, 5'(s), 5'h00);
		end
		do_cmd(IMP_CMD_DISABLE, 5'h10);
		fire(24'h010000);
		expect_srv(0, 5'h00, 5'h00);
		do_cmd(IMP_CMD_ENABLE, 5'h10);
		expect_srv(1, 5'h10, 5'h00);
		repeat (20) begin
			a = 5'($urandom_range(0, 22));
			b = 5'($urandom_range(0, 22));
			if (a == b) b = (a == 5'h16) ? 5'h00 : a + 5'h01;
			fire((24'h000001 << a) | (24'h000001 << b));
			expect_srv(2, lower(a, b), (a < b) ? b : a);
		end
		// Source 20 made high priority must beat any lower index source
		do_cmd(IMP_CMD_PRIO_HIGH, 5'h14);
		repeat (10) begin
			a = 5'($urandom_range(0, 19));
			fire((24'h000001 << a) | 24'h100000);
			expect_srv(2, 5'h14, a);
		end
		end_sim();
	end
endmodule
